/* rtl/rtcw_regs.vh */
`ifndef RTCW_REGS_VH
`define RTCW_REGS_VH
// register offsets
`define RTCW_OFF_HSEC 6'h00
`define RTCW_OFF_SEC 6'h01
`define RTCW_OFF_MIN 6'h02
`define RTCW_OFF_MIN_ALM 6'h03
`define RTCW_OFF_HOUR 6'h04
`define RTCW_OFF_HOUR_ALM 6'h05
`define RTCW_OFF_WDAY 6'h06
`define RTCW_OFF_WDAY_ALM 6'h07
`define RTCW_OFF_DATE 6'h08
`define RTCW_OFF_MONTH 6'h09
`define RTCW_OFF_YEAR 6'h0A
`define RTCW_OFF_CMD 6'h0B
`define RTCW_OFF_WD_FRAC 6'h0C
`define RTCW_OFF_WD_SEC 6'h0D
`define RTCW_OFF_RAM_LO 6'h0E
`define RTCW_OFF_RAM_HI 6'h3F
// command register fields
`define RTCW_CMD_TE 7
`define RTCW_CMD_ISEL 6
`define RTCW_CMD_POL 5
`define RTCW_CMD_PULSE 4
`define RTCW_CMD_WAM 3
`define RTCW_CMD_TDM 2
`define RTCW_CMD_WAF 1
`define RTCW_CMD_TDF 0
// other fields
`define RTCW_MONTH_OSC_N 7
`define RTCW_HOUR_12 6
`define RTCW_ALM_MASK 7
// reset values
`define RTCW_CMD_RST 6'h00
`define RTCW_MONTH_RST 8'h80
// timing
`define RTCW_CLK_HZ 200000000
`define RTCW_TICK_NS 10000000
`define RTCW_TICK_CYC (`RTCW_CLK_HZ / 100)
`define RTCW_PULSE_MS 3
`define RTCW_PULSE_CYC (`RTCW_CLK_HZ / 1000 * `RTCW_PULSE_MS)
`define RTCW_INT_NS 100
`define RTCW_INT_CYC ((`RTCW_INT_NS * (`RTCW_CLK_HZ / 1000000)) / 1000)
`endif

/* rtl/rtcw_bcd_digit.v */
`timescale 1ns/1ps
`default_nettype none
// one bcd field: increments with wrap from max back to min
module rtcw_bcd_digit (
	input wire [7:0] value,
	input wire [7:0] max_value,
	input wire [7:0] min_value,
	output reg [7:0] next_value,
	output reg wrap
);
	// ---------------------------------------------
	// bcd increment
	// ---------------------------------------------
	always @* begin
		wrap = (value >= max_value);
		if (wrap)
			next_value = min_value;
		else if (value[3:0] >= 4'h9)
			next_value = {value[7:4] + 4'h1, 4'h0};
		else
			next_value = {value[7:4], value[3:0] + 4'h1};
	end
endmodule
`default_nettype wire

/* rtl/rtcw_clock.v */
`include "rtcw_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rtcw_clock #(
	parameter TICK_CYC = `RTCW_TICK_CYC,
	parameter PULSE_CYC = `RTCW_PULSE_CYC
) (
	input wire clk,
	input wire rst,
	input wire clock_chip_select_n,
	input wire clock_write_strobe_n,
	input wire clock_output_strobe_n,
	input wire [5:0] addr,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	output reg int_out
);
	// ---------------------------------------------
	// storage
	// ---------------------------------------------
	reg [7:0] ext [0:10]; // visible time, indices 0..A (3,5,7 unused)
	reg [7:0] cnt [0:10]; // internal counters
	reg [7:0] alm [0:2];
	reg [7:0] ram [14:63];
	reg [7:0] cmd;
	reg [7:0] wd_frac;
	reg [7:0] wd_sec;
	reg [15:0] wd_cnt;
	reg [15:0] wd_load;
	reg wd_run;
	reg [31:0] tick;
	reg [31:0] pulse_cnt;
	reg [10:0] dirty;
	reg acc_q;
	reg wr_q;
	reg td_int;
	reg wd_int;
	reg pulse_act;
	wire access = ~clock_chip_select_n;
	wire wr = access & ~clock_write_strobe_n;
	wire rd = access & clock_write_strobe_n & ~clock_output_strobe_n;
	wire acc_start = access & ~acc_q;
	wire wr_end = wr_q & ~wr;
	wire osc_run = ~cnt[9][`RTCW_MONTH_OSC_N];
	wire te = cmd[`RTCW_CMD_TE];
	wire tick_now = osc_run && (tick == TICK_CYC - 1);
	wire is_alm = (addr == `RTCW_OFF_MIN_ALM) || (addr == `RTCW_OFF_HOUR_ALM) || (addr == `RTCW_OFF_WDAY_ALM);
	wire is_wd = (addr == `RTCW_OFF_WD_FRAC) || (addr == `RTCW_OFF_WD_SEC);
	wire pulse_mode = cmd[`RTCW_CMD_PULSE];
	// ---------------------------------------------
	// bcd carry chain
	// ---------------------------------------------
	reg [7:0] month_max;
	wire [7:0] hsec_n, sec_n, min_n, wday_n, date_n, mon_n, year_n;
	wire hsec_w, sec_w, min_w, date_w, mon_w;
	wire leap = ~cnt[10][4] ? (cnt[10][1:0] == 2'b00) : (cnt[10][1:0] == 2'b10);
	always @* begin
		case (cnt[9][4:0])
			5'h02: month_max = leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: month_max = 8'h30;
			default: month_max = 8'h31;
		endcase
	end
	rtcw_bcd_digit u_hsec (.value(cnt[0]), .max_value(8'h99), .min_value(8'h00), .next_value(hsec_n), .wrap(hsec_w));
	rtcw_bcd_digit u_sec (.value(cnt[1]), .max_value(8'h59), .min_value(8'h00), .next_value(sec_n), .wrap(sec_w));
	rtcw_bcd_digit u_min (.value(cnt[2]), .max_value(8'h59), .min_value(8'h00), .next_value(min_n), .wrap(min_w));
	rtcw_bcd_digit u_wday (.value(cnt[6]), .max_value(8'h07), .min_value(8'h01), .next_value(wday_n), .wrap());
	rtcw_bcd_digit u_date (.value({2'b00, cnt[8][5:0]}), .max_value(month_max), .min_value(8'h01),
		.next_value(date_n), .wrap(date_w));
	rtcw_bcd_digit u_mon (.value({3'b000, cnt[9][4:0]}), .max_value(8'h12), .min_value(8'h01),
		.next_value(mon_n), .wrap(mon_w));
	rtcw_bcd_digit u_year (.value(cnt[10]), .max_value(8'h99), .min_value(8'h00), .next_value(year_n), .wrap());
	// hour increment honouring 12/24 mode
	reg [7:0] hour_n;
	reg hour_w;
	reg [3:0] hb;
	always @* begin
		hour_w = 1'b0;
		hb = cnt[4][3:0];
		if (cnt[4][`RTCW_HOUR_12]) begin
			hour_n = cnt[4];
			if (cnt[4][4:0] == 5'h12)
				hour_n[4:0] = 5'h01;
			else if (cnt[4][4:0] == 5'h11) begin
				hour_n[4:0] = 5'h12;
				hour_n[5] = ~cnt[4][5];
				hour_w = cnt[4][5];
			end else if (hb == 4'h9)
				hour_n[4:0] = 5'h10;
			else
				hour_n[3:0] = hb + 4'h1;
		end else begin
			if (cnt[4][5:0] == 6'h23) begin
				hour_n = 8'h00;
				hour_w = 1'b1;
			end else if (hb == 4'h9)
				hour_n = {2'b00, cnt[4][5:4] + 2'b01, 4'h0};
			else
				hour_n = {2'b00, cnt[4][5:4], hb + 4'h1};
		end
	end
	// ---------------------------------------------
	// alarm match
	// ---------------------------------------------
	wire m_min = alm[0][`RTCW_ALM_MASK] | (alm[0][6:0] == min_n[6:0]);
	wire [7:0] hour_eff = min_w ? hour_n : cnt[4];
	wire m_hour = alm[1][`RTCW_ALM_MASK] | (alm[1][6:0] == hour_eff[6:0]);
	wire hday_roll = min_w & hour_w;
	wire [7:0] wday_eff = hday_roll ? wday_n : cnt[6];
	wire m_day = alm[2][`RTCW_ALM_MASK] | (alm[2][2:0] == wday_eff[2:0]);
	// alarm fires on the minute rollover of the seconds field, compared with the new time
	wire td_event = tick_now & hsec_w & sec_w & m_min & m_hour & m_day;
	wire wd_event = wd_run && tick_now && (wd_cnt == 16'h0001);
	// ---------------------------------------------
	// tick counter and bus edge tracking
	// ---------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick <= 32'h0;
			acc_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			tick <= (!osc_run || tick_now) ? 32'h0 : tick + 32'h1;
			acc_q <= access;
			wr_q <= wr;
		end
	end
	// ---------------------------------------------
	// time counters, visible copy and user ram
	// ---------------------------------------------
	integer i;
	reg [7:0] wmask;
	always @* begin
		case (addr)
			`RTCW_OFF_SEC, `RTCW_OFF_MIN: wmask = 8'h7F;
			`RTCW_OFF_HOUR: wmask = 8'h7F;
			`RTCW_OFF_WDAY: wmask = 8'h07;
			`RTCW_OFF_DATE: wmask = 8'hBF;
			`RTCW_OFF_MONTH: wmask = 8'hDF;
			default: wmask = 8'hFF;
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i <= 10; i = i + 1) begin
				ext[i] <= 8'h00;
				cnt[i] <= 8'h00;
			end
			cnt[9] <= `RTCW_MONTH_RST;
			ext[9] <= `RTCW_MONTH_RST;
			dirty <= 11'h000;
			alm[0] <= 8'h00;
			alm[1] <= 8'h00;
			alm[2] <= 8'h00;
		end else begin
			if (tick_now) begin
				cnt[0] <= hsec_n;
				if (hsec_w) begin
					cnt[1] <= sec_n;
					if (sec_w) begin
						cnt[2] <= min_n;
						if (min_w) begin
							cnt[4] <= hour_n;
							if (hour_w) begin
								cnt[6] <= wday_n;
								cnt[8] <= {cnt[8][7:6], date_n[5:0]};
								if (date_w) begin
									cnt[9] <= {cnt[9][7:5], mon_n[4:0]};
									if (mon_w)
										cnt[10] <= year_n;
								end
							end
						end
					end
				end
			end
			if (te && dirty != 11'h000) begin
				for (i = 0; i <= 10; i = i + 1)
					if (dirty[i])
						cnt[i] <= ext[i];
				dirty <= 11'h000;
			end else if (te && tick_now) begin
				for (i = 0; i <= 10; i = i + 1)
					ext[i] <= cnt[i];
			end
			if (wr_end) begin
				case (addr)
					`RTCW_OFF_MIN_ALM: alm[0] <= data_in;
					`RTCW_OFF_HOUR_ALM: alm[1] <= data_in;
					`RTCW_OFF_WDAY_ALM: alm[2] <= data_in & 8'h87;
					`RTCW_OFF_HSEC, `RTCW_OFF_SEC, `RTCW_OFF_MIN, `RTCW_OFF_HOUR, `RTCW_OFF_WDAY,
					`RTCW_OFF_DATE, `RTCW_OFF_YEAR: begin
						ext[addr[3:0]] <= data_in & wmask;
						if (te)
							cnt[addr[3:0]] <= data_in & wmask;
						else
							dirty[addr[3:0]] <= 1'b1;
					end
					`RTCW_OFF_MONTH: begin
						ext[9] <= data_in & wmask;
						cnt[9] <= data_in & wmask;
					end
					default: ;
				endcase
			end
		end
	end
	// user ram writes
	always @(posedge clk) begin
		if (wr_end && addr >= `RTCW_OFF_RAM_LO)
			ram[addr] <= data_in;
	end
	// ---------------------------------------------
	// watchdog and command/flags
	// ---------------------------------------------
	wire wd_touch = acc_start & is_wd;
	wire td_touch = acc_start & is_alm;
	wire [7:0] nf = (wr_end && addr == `RTCW_OFF_WD_FRAC) ? data_in : wd_frac;
	wire [7:0] ns = (wr_end && addr == `RTCW_OFF_WD_SEC) ? data_in : wd_sec;
	wire [15:0] nload = {ns, nf};
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wd_frac <= 8'h00;
			wd_sec <= 8'h00;
			wd_cnt <= 16'h0;
			wd_run <= 1'b0;
			wd_load <= 16'h0;
			cmd <= {2'b00, `RTCW_CMD_RST};
			td_int <= 1'b0;
			wd_int <= 1'b0;
			pulse_act <= 1'b0;
			pulse_cnt <= 32'h0;
		end else begin
			wd_frac <= nf;
			wd_sec <= ns;
			if (wd_touch || (wr_end && is_wd)) begin
				wd_cnt <= nload;
				wd_load <= nload;
				wd_run <= (nload != 16'h0000);
			end else if (wd_event) begin
				wd_run <= 1'b0;
			end else if (wd_run && tick_now) begin
				wd_cnt[3:0] <= (wd_cnt[3:0] == 4'h0) ? 4'h9 : wd_cnt[3:0] - 4'h1;
				if (wd_cnt[3:0] == 4'h0) begin
					wd_cnt[7:4] <= (wd_cnt[7:4] == 4'h0) ? 4'h9 : wd_cnt[7:4] - 4'h1;
					if (wd_cnt[7:4] == 4'h0) begin
						wd_cnt[11:8] <= (wd_cnt[11:8] == 4'h0) ? 4'h9 : wd_cnt[11:8] - 4'h1;
						if (wd_cnt[11:8] == 4'h0)
							wd_cnt[15:12] <= wd_cnt[15:12] - 4'h1;
					end
				end
			end
			if (wr_end && addr == `RTCW_OFF_CMD)
				cmd[7:2] <= data_in[7:2];
			// flags: alarm set wins over an access clear
			if (td_event)
				cmd[`RTCW_CMD_TDF] <= 1'b1;
			else if (td_touch || (pulse_mode && !pulse_act))
				cmd[`RTCW_CMD_TDF] <= 1'b0;
			if (wd_event)
				cmd[`RTCW_CMD_WAF] <= 1'b1;
			else if (wd_touch || (pulse_mode && !pulse_act))
				cmd[`RTCW_CMD_WAF] <= 1'b0;
			if (td_event && !cmd[`RTCW_CMD_TDM])
				td_int <= 1'b1;
			else if (td_touch)
				td_int <= 1'b0;
			if (wd_event && !cmd[`RTCW_CMD_WAM])
				wd_int <= 1'b1;
			else if (wd_touch)
				wd_int <= 1'b0;
			// pulse timer runs at least 3 ms
			if ((td_event && !cmd[`RTCW_CMD_TDM] && !cmd[`RTCW_CMD_ISEL]) ||
				(wd_event && !cmd[`RTCW_CMD_WAM] && cmd[`RTCW_CMD_ISEL])) begin
				pulse_act <= 1'b1;
				pulse_cnt <= 32'h0;
			end else if (pulse_act) begin
				if (pulse_cnt == PULSE_CYC - 1)
					pulse_act <= 1'b0;
				else
					pulse_cnt <= pulse_cnt + 32'h1;
			end
		end
	end
	// ---------------------------------------------
	// output pin and read data
	// ---------------------------------------------
	wire src_int = cmd[`RTCW_CMD_ISEL] ? wd_int : td_int;
	wire pin_act = pulse_mode ? pulse_act : src_int;
	reg [7:0] rdata;
	always @* begin
		if (addr <= `RTCW_OFF_YEAR && addr != `RTCW_OFF_MIN_ALM && addr != `RTCW_OFF_HOUR_ALM &&
			addr != `RTCW_OFF_WDAY_ALM)
			rdata = ext[addr[3:0]];
		else case (addr)
			`RTCW_OFF_MIN_ALM: rdata = alm[0];
			`RTCW_OFF_HOUR_ALM: rdata = alm[1];
			`RTCW_OFF_WDAY_ALM: rdata = alm[2];
			`RTCW_OFF_CMD: rdata = cmd;
			`RTCW_OFF_WD_FRAC: rdata = wd_frac;
			`RTCW_OFF_WD_SEC: rdata = wd_sec;
			default: rdata = ram[addr];
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
			int_out <= 1'b1;
		end else begin
			data_out <= rdata;
			data_oe <= rd;
			int_out <= cmd[`RTCW_CMD_POL] ? pin_act : ~pin_act;
		end
	end
endmodule
`default_nettype wire

/* verification/rtcw_props.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// checker
// --------
module rtcw_props #(
	parameter PULSE_CYC = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clock_chip_select_n,
	input wire logic clock_write_strobe_n,
	input wire logic clock_output_strobe_n,
	input wire logic [5:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic int_out
);
	logic [7:0] cmd, wlo, whi, ram, cnt, quiet;
	logic ram_v, pact;
	wire rd = !clock_chip_select_n && clock_write_strobe_n && !clock_output_strobe_n;
	wire wr = !clock_chip_select_n && !clock_write_strobe_n;
	wire act = int_out == cmd[5];
	wire wdz = wlo == 8'h00 && whi == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// shadows of written registers, idle and pulse counters
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd <= 8'h00;
			wlo <= 8'hFF;
			whi <= 8'hFF;
			ram <= 8'h00;
			ram_v <= 1'b0;
			cnt <= 8'h00;
			quiet <= 8'h00;
			pact <= 1'b0;
		end else begin
			if (wr && addr == 6'h0B) cmd <= data_in;
			if (wr && addr == 6'h0C) wlo <= data_in;
			if (wr && addr == 6'h0D) whi <= data_in;
			if (wr && addr == 6'h0E) ram <= data_in;
			if (wr && addr == 6'h0E) ram_v <= 1'b1;
			quiet <= !clock_chip_select_n ? 8'h00 : (quiet == 8'hFF ? quiet : quiet + 8'h01);
			pact <= act;
			if (act) cnt <= pact ? cnt + 8'h01 : 8'h01;
		end
	end
	AST_RD_OE: assert property (rd ##1 rd |-> data_oe) else $error("read not driven");
	AST_OE_OFF: assert property (!rd && !$past(rd) |-> !data_oe) else $error("bus driven outside read");
	AST_RAM_RD: assert property (rd ##1 rd && addr == 6'h0E && ram_v |-> data_out == ram)
		else $error("user byte lost");
	AST_TOD_CLR: assert property ($fell(clock_chip_select_n) && (addr == 6'h03 || addr == 6'h05 || addr == 6'h07)
		&& !cmd[6] && !cmd[4] |-> ##[1:3] !act) else $error("daytime interrupt not cleared");
	AST_WD_CLR: assert property ($fell(clock_chip_select_n) && (addr == 6'h0C || addr == 6'h0D)
		&& cmd[6] && !cmd[4] |-> ##[1:3] !act) else $error("watchdog interrupt not cleared");
	AST_WD_OFF: assert property (quiet > 8'd5 && wdz && cmd[6] |-> !act) else $error("disabled watchdog fired");
	AST_MASK: assert property (quiet > 8'd5 && (cmd[3] && cmd[6] || cmd[2] && !cmd[6]) |-> !act)
		else $error("masked alarm reached pin");
	AST_PULSE_MIN: assert property (cmd[4] && pact && !act && quiet > 8'd15 |-> cnt >= PULSE_CYC - 1)
		else $error("pulse too short");
	AST_PULSE_MAX: assert property (cmd[4] && act |-> cnt <= PULSE_CYC + 8) else $error("pulse not released");
	cover property (act && cmd[4]);
	cover property (act && !cmd[4] && !cmd[6]);
	cover property (rd ##1 rd && addr == 6'h0E);
endmodule
bind rtcw_clock rtcw_props #(.PULSE_CYC(PULSE_CYC)) i_props (.clk(clk), .rst(rst),
	.clock_chip_select_n(clock_chip_select_n), .clock_write_strobe_n(clock_write_strobe_n),
	.clock_output_strobe_n(clock_output_strobe_n), .addr(addr), .data_in(data_in), .data_out(data_out),
	.data_oe(data_oe), .int_out(int_out));
`default_nettype wire

/* verification/rtcw_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host on the byte-wide clock port, drives at falling edges
module rtcw_host (
	input wire logic clk,
	input wire logic [7:0] din,
	output logic cs_n,
	output logic we_n,
	output logic oe_n,
	output logic [5:0] addr,
	output logic [7:0] dout
);
	// idle bus at time zero
	initial begin
		cs_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		addr = 6'h00;
		dout = 8'h00;
	end
	// write: strobe one cycle, then released data shows inverse
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		we_n = 1'b0;
		addr = a;
		dout = d;
		@(negedge clk);
		we_n = 1'b1;
		cs_n = 1'b1;
		@(negedge clk);
		dout = ~d;
		@(negedge clk);
	endtask
	// read: data taken after the registered answer settles
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		oe_n = 1'b0;
		addr = a;
		@(negedge clk);
		@(negedge clk);
		d = din;
		cs_n = 1'b1;
		oe_n = 1'b1;
		@(negedge clk);
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

/* verification/rtcw_clock_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcw_clock_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	wire cs, we, oe, doe, irq;
	wire [5:0] a;
	wire [7:0] di, dq;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	logic [7:0] v, u;
	always #2.5 clk = ~clk;
	rtcw_host i_host (.clk(clk), .din(dq), .cs_n(cs), .we_n(we), .oe_n(oe), .addr(a), .dout(di));
	rtcw_clock #(.TICK_CYC(20), .PULSE_CYC(10)) i_dut (.clk(clk), .rst(rst), .clock_chip_select_n(cs),
		.clock_write_strobe_n(we), .clock_output_strobe_n(oe), .addr(a), .data_in(di), .data_out(dq),
		.data_oe(doe), .int_out(irq));
	// ----------------
	// helpers
	// ----------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rdc(input logic [5:0] ad, input logic [7:0] exp, input string name);
		i_host.rd(ad, v);
		chk(name, exp, v);
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("irq raised", 8'h01, {7'h00, irq});
	endtask
	// run ceiling against hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// ----------------
	// scenarios
	// ----------------
	task automatic t_regs();
		chk("irq idle", 8'h01, {7'h00, irq});
		rdc(6'h0B, 8'h00, "cmd");
		rdc(6'h09, 8'h80, "month");
		i_host.wr(6'h01, 8'hD9);
		rdc(6'h01, 8'h59, "sec");
		i_host.wr(6'h06, 8'hFF);
		rdc(6'h06, 8'h07, "wday");
		i_host.wr(6'h07, 8'hFF);
		rdc(6'h07, 8'h87, "wday alarm");
		i_host.wr(6'h0E, 8'hA5);
		i_host.wr(6'h3F, 8'h5A);
		rdc(6'h0E, 8'hA5, "ram lo");
		rdc(6'h3F, 8'h5A, "ram hi");
		i_host.wr(6'h08, 8'h15);
		i_host.wr(6'h09, 8'h41);
	endtask
	task automatic t_freeze();
		i_host.wr(6'h0B, 8'h20);
		i_host.rd(6'h00, u);
		repeat (60) @(negedge clk);
		rdc(6'h00, u, "frozen");
		i_host.wr(6'h0B, 8'hA0);
		i_host.rd(6'h00, u);
		repeat (60) @(negedge clk);
		i_host.rd(6'h00, v);
		chk("running", 8'h01, {7'h00, u !== v});
		i_host.wr(6'h09, 8'hC1);
		i_host.rd(6'h00, u);
		repeat (60) @(negedge clk);
		rdc(6'h00, u, "osc off");
		i_host.wr(6'h09, 8'h41);
	endtask
	task automatic t_wdog();
		i_host.wr(6'h0B, 8'hE0);
		i_host.wr(6'h0C, 8'h05);
		i_host.wr(6'h0D, 8'h00);
		rdc(6'h0C, 8'h05, "wd frac");
		rdc(6'h0D, 8'h00, "wd sec");
		chk("irq low", 8'h00, {7'h00, irq});
		wait_irq(300);
		chk("wd delay", 8'h01, {7'h00, n >= 70 && n <= 130});
		rdc(6'h0B, 8'hE2, "wd flag");
		i_host.wr(6'h0B, 8'hE0);
		rdc(6'h0B, 8'hE2, "flag ro");
		rdc(6'h0C, 8'h05, "wd reload");
		chk("irq clr", 8'h00, {7'h00, irq});
		rdc(6'h0B, 8'hE0, "flag clr");
	endtask
	task automatic t_mask_pulse();
		i_host.wr(6'h0B, 8'hE8);
		rdc(6'h0C, 8'h05, "wd mask");
		repeat (200) @(negedge clk);
		chk("masked", 8'h00, {7'h00, irq});
		rdc(6'h0B, 8'hEA, "flag masked");
		i_host.wr(6'h0B, 8'hF0);
		rdc(6'h0C, 8'h05, "wd pulse");
		wait_irq(300);
		rdc(6'h0B, 8'hF2, "pulse flag");
		repeat (30) @(negedge clk);
		chk("pulse end", 8'h00, {7'h00, irq});
		rdc(6'h0B, 8'hF0, "flag gone");
		i_host.wr(6'h0C, 8'h00);
		i_host.wr(6'h0D, 8'h00);
		i_host.wr(6'h0B, 8'hE0);
		repeat (300) @(negedge clk);
		chk("wd off", 8'h00, {7'h00, irq});
	endtask
	task automatic t_alarm();
		i_host.wr(6'h03, 8'h80);
		i_host.wr(6'h05, 8'h80);
		i_host.wr(6'h07, 8'h80);
		i_host.wr(6'h0B, 8'h20);
		i_host.wr(6'h01, 8'h59);
		i_host.wr(6'h00, 8'h95);
		i_host.wr(6'h0B, 8'hA0);
		wait_irq(400);
		rdc(6'h0B, 8'hA1, "tod flag");
		rdc(6'h03, 8'h80, "min alarm");
		chk("tod clr", 8'h00, {7'h00, irq});
		rdc(6'h0B, 8'hA0, "tod flag clr");
	endtask
	task automatic t_roll();
		i_host.wr(6'h0B, 8'h20);
		i_host.wr(6'h04, 8'h71);
		i_host.wr(6'h02, 8'h59);
		i_host.wr(6'h01, 8'h59);
		i_host.wr(6'h00, 8'h95);
		i_host.wr(6'h0B, 8'hA0);
		repeat (200) @(negedge clk);
		rdc(6'h02, 8'h00, "min roll");
		rdc(6'h04, 8'h52, "12h pm to am");
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_regs();
		t_freeze();
		t_wdog();
		t_mask_pulse();
		t_alarm();
		t_roll();
		conclude();
	end
endmodule
`default_nettype wire
